// [pkg/irq_intake_pkg.sv]
/*
  Constants and carrier types for the interrupt request intake block.
  Assumes a 16-bit register port with word indices and 12-bit event codes.
*/
package irq_intake_pkg;

  // ------------------------------------------------------------
  // Register indices
  // ------------------------------------------------------------
  localparam logic [3:0] IDX_PRIO_C = 4'h0;
  localparam logic [3:0] IDX_PRIO_D = 4'h1;
  localparam logic [3:0] IDX_MOD_PRIO_FIRST = 4'h2;
  localparam logic [3:0] IDX_MOD_PRIO_LAST = 4'h9;
  localparam logic [3:0] IDX_EXT_FLAGS = 4'ha;
  localparam logic [3:0] IDX_SENSE = 4'hb;
  localparam logic [3:0] IDX_EVENT = 4'hc;
  localparam logic [3:0] IDX_EVENT_ALT = 4'hd;
  localparam logic [3:0] IDX_STATUS = 4'he;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int PINT_LO_PRIO_POS = 12;
  localparam int PINT_HI_PRIO_POS = 8;
  localparam int STAT_VALID_POS = 15;
  localparam int STAT_LEVEL_POS = 8;
  localparam int STAT_BUS_POS = 0;
  localparam logic [15:0] PRIO_RESET = 16'h0000;
  localparam logic [5:0] SENSE_RESET = 6'h00;

  // ------------------------------------------------------------
  // Levels and event codes
  // ------------------------------------------------------------
  localparam logic [3:0] LEVEL_NONE = 4'h0;
  localparam logic [3:0] LEVEL_DEBUG = 4'hf;
  localparam logic [3:0] BUS_IDLE = 4'hf;
  localparam logic [11:0] CODE_DEBUG = 12'h5e0;
  localparam logic [11:0] CODE_IRQ_BASE = 12'h600;
  localparam logic [11:0] CODE_PINT_LO = 12'h700;
  localparam logic [11:0] CODE_PINT_HI = 12'h720;
  localparam logic [11:0] CODE_BUS = 12'h200;
  localparam logic [11:0] CODE_MOD_BASE = 12'h800;
  localparam logic [11:0] CODE_STEP = 12'h020;
  localparam logic [11:0] CODE_MOD_STEP = 12'h040;

  typedef struct packed {
    logic valid;
    logic [3:0] level;
    logic [11:0] code;
    logic [11:0] code_alt;
  } irq_req_t;

endpackage

// [logic/irq_source_intake.sv]
/*
  Interrupt request intake: request pins, encoded priority bus, port pins
  and on-chip module lines, priority selection, event codes and wake-up.
  Assumes pins are synchronous inputs, rtc_tick is a one-cycle pulse from
  the running real-time clock, and the CPU pulses cpu_accept on acceptance.
*/
`timescale 1ns/1ns

// Summary of operation
// - Six request pins, level or edge sensed, each with a 0-15 priority.
// - Edge flag clears only after software reads 1 then writes 0.
// - Accepting any request leaves the CPU mask level untouched.
// - Request pin above mask wakes from standby, only with RTC running.
// - Bus code 0000 is level 15, each step lower, 1111 no request.
// - Bus value taken only after two equal consecutive samples.
// - In standby the bus filter runs on RTC ticks, else no wake.
// - Sixteen level port pins, one priority per group of eight.
// - Port pin above mask wakes from standby, only with RTC running.
// - Ten module sources, each recorded with its own event code.
// - Module priorities programmable 0-15, debug source fixed at 15.
// - Priority 0 masks the source; its requests are ignored.
// - Equal levels resolved by fixed default source order.
module irq_source_intake #(
  parameter int NUM_MOD = 10
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rdata,
  input wire logic [5:0] ext_request_pins_n,
  input wire logic [3:0] encoded_prio_bus,
  input wire logic [15:0] port_request_pins,
  input wire logic [NUM_MOD-1:0] module_irq,
  input wire logic [3:0] cpu_mask_level,
  input wire logic cpu_accept,
  input wire logic standby,
  input wire logic rtc_running,
  input wire logic rtc_tick,
  output irq_intake_pkg::irq_req_t req,
  output logic wake
);

  localparam int NSRC = NUM_MOD + 9;

  // ------------------------------------------------------------
  // Parameter check
  // ------------------------------------------------------------
  if (NUM_MOD < 2 || NUM_MOD > 33) begin : g_bad_num_mod
    $error("NUM_MOD must lie between 2 and 33");
  end

  typedef struct packed {
    logic [5:0] ext_s1;
    logic [5:0] ext_s2;
    logic [5:0] ext_prev;
    logic [5:0] flags;
    logic [5:0] armed;
    logic [5:0] sense;
    logic [3:0] bus_s1;
    logic [3:0] bus_s2;
    logic [3:0] bus_prev;
    logic [3:0] bus_stable;
    logic [15:0] pint_s1;
    logic [15:0] pint_s2;
    logic [15:0] prio_c;
    logic [15:0] prio_d;
    logic [7:0][15:0] mod_prio;
    logic [15:0] rdata;
    logic [11:0] event_code;
    logic [11:0] event_code_alt;
    irq_intake_pkg::irq_req_t req;
    logic wake;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic rst_q1_r;
  logic rst_q2_r;
  logic sample_en;
  logic [NSRC-1:0] src_act;
  logic [NSRC-1:0][3:0] src_lvl;
  logic [NSRC-1:0][11:0] src_code;
  logic [NSRC-1:0][11:0] src_alt;

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_q1_r <= 1'b0;
      rst_q2_r <= 1'b0;
    end else begin
      rst_q1_r <= 1'b1;
      rst_q2_r <= rst_q1_r;
    end
  end

  // RTC paced sampling
  // Peripheral clock is stopped in standby, so RTC ticks pace the pins.
  assign sample_en = !standby || (rtc_running && rtc_tick);

  // ------------------------------------------------------------
  // Source table, in default order
  // ------------------------------------------------------------
  always_comb begin
    src_act = '0;
    src_lvl = '0;
    src_code = '0;
    src_alt = '0;
    src_act[0] = module_irq[NUM_MOD-1];
    src_lvl[0] = irq_intake_pkg::LEVEL_DEBUG;
    src_code[0] = irq_intake_pkg::CODE_DEBUG;
    src_alt[0] = irq_intake_pkg::CODE_DEBUG;
    src_act[1] = st_r.bus_stable != irq_intake_pkg::BUS_IDLE;
    src_lvl[1] = irq_intake_pkg::BUS_IDLE ^ st_r.bus_stable;
    src_code[1] = irq_intake_pkg::CODE_BUS;
    src_alt[1] = irq_intake_pkg::CODE_BUS + {3'h0, st_r.bus_stable, 5'h00};
    for (int i = 0; i < 6; i++) begin
      src_act[2+i] = st_r.flags[i];
      src_lvl[2+i] = (i < 4) ? st_r.prio_c[4*(i%4) +: 4] : st_r.prio_d[4*(i%4) +: 4];
      src_code[2+i] = irq_intake_pkg::CODE_IRQ_BASE + 12'(i) * irq_intake_pkg::CODE_STEP;
      src_alt[2+i] = src_code[2+i];
    end
    src_act[8] = |st_r.pint_s2[7:0];
    src_lvl[8] = st_r.prio_d[irq_intake_pkg::PINT_LO_PRIO_POS +: 4];
    src_code[8] = irq_intake_pkg::CODE_PINT_LO;
    src_alt[8] = irq_intake_pkg::CODE_PINT_LO;
    src_act[9] = |st_r.pint_s2[15:8];
    src_lvl[9] = st_r.prio_d[irq_intake_pkg::PINT_HI_PRIO_POS +: 4];
    src_code[9] = irq_intake_pkg::CODE_PINT_HI;
    src_alt[9] = irq_intake_pkg::CODE_PINT_HI;
    for (int m = 0; m < NUM_MOD - 1; m++) begin
      src_act[10+m] = module_irq[m];
      src_lvl[10+m] = st_r.mod_prio[m/4][15-4*(m%4) -: 4];
      src_code[10+m] = irq_intake_pkg::CODE_MOD_BASE + 12'(m) * irq_intake_pkg::CODE_MOD_STEP;
      src_alt[10+m] = src_code[10+m];
    end
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic [5:0] falls;
    logic [3:0] best_lvl;
    logic [11:0] best_code;
    logic [11:0] best_alt;
    logic pins_wake;
    falls = '0;
    best_lvl = irq_intake_pkg::LEVEL_NONE;
    best_code = '0;
    best_alt = '0;
    pins_wake = 1'b0;
    st_nxt = st_r;

    if (sample_en) begin
      st_nxt.ext_s1 = ext_request_pins_n;
      st_nxt.ext_s2 = st_r.ext_s1;
      st_nxt.ext_prev = st_r.ext_s2;
      st_nxt.bus_s1 = encoded_prio_bus;
      st_nxt.bus_s2 = st_r.bus_s1;
      st_nxt.bus_prev = st_r.bus_s2;
      st_nxt.pint_s1 = port_request_pins;
      st_nxt.pint_s2 = st_r.pint_s1;
      if (st_r.bus_s2 == st_r.bus_prev) begin
        st_nxt.bus_stable = st_r.bus_s2;
      end
      falls = st_r.ext_prev & ~st_r.ext_s2;
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    st_nxt.rdata = '0;
    if (rd_stb) begin
      if (addr == irq_intake_pkg::IDX_PRIO_C) begin
        st_nxt.rdata = st_r.prio_c;
      end else if (addr == irq_intake_pkg::IDX_PRIO_D) begin
        st_nxt.rdata = st_r.prio_d;
      end else if (addr >= irq_intake_pkg::IDX_MOD_PRIO_FIRST && addr <= irq_intake_pkg::IDX_MOD_PRIO_LAST) begin
        st_nxt.rdata = st_r.mod_prio[3'(addr - irq_intake_pkg::IDX_MOD_PRIO_FIRST)];
      end else if (addr == irq_intake_pkg::IDX_EXT_FLAGS) begin
        st_nxt.rdata = {10'h000, st_r.flags};
        st_nxt.armed = st_r.armed | (st_r.flags & st_r.sense);
      end else if (addr == irq_intake_pkg::IDX_SENSE) begin
        st_nxt.rdata = {10'h000, st_r.sense};
      end else if (addr == irq_intake_pkg::IDX_EVENT) begin
        st_nxt.rdata = {4'h0, st_r.event_code};
      end else if (addr == irq_intake_pkg::IDX_EVENT_ALT) begin
        st_nxt.rdata = {4'h0, st_r.event_code_alt};
      end else if (addr == irq_intake_pkg::IDX_STATUS) begin
        st_nxt.rdata[irq_intake_pkg::STAT_VALID_POS] = st_r.req.valid;
        st_nxt.rdata[irq_intake_pkg::STAT_LEVEL_POS +: 4] = st_r.req.level;
        st_nxt.rdata[irq_intake_pkg::STAT_BUS_POS +: 4] = st_r.bus_stable;
      end
    end
    if (wr_stb) begin
      if (addr == irq_intake_pkg::IDX_PRIO_C) begin
        st_nxt.prio_c = wdata;
      end else if (addr == irq_intake_pkg::IDX_PRIO_D) begin
        st_nxt.prio_d = wdata;
      end else if (addr >= irq_intake_pkg::IDX_MOD_PRIO_FIRST && addr <= irq_intake_pkg::IDX_MOD_PRIO_LAST) begin
        st_nxt.mod_prio[3'(addr - irq_intake_pkg::IDX_MOD_PRIO_FIRST)] = wdata;
      end else if (addr == irq_intake_pkg::IDX_EXT_FLAGS) begin
        st_nxt.flags = st_r.flags & (wdata[5:0] | ~st_r.armed);
        st_nxt.armed = st_r.armed & wdata[5:0];
      end else if (addr == irq_intake_pkg::IDX_SENSE) begin
        st_nxt.sense = wdata[5:0];
      end
    end

    for (int i = 0; i < 6; i++) begin
      if (!st_r.sense[i]) begin
        st_nxt.flags[i] = !st_r.ext_s2[i];
        st_nxt.armed[i] = 1'b0;
      end else if (falls[i]) begin
        st_nxt.flags[i] = 1'b1;
      end
    end

    for (int s = 0; s < NSRC; s++) begin
      if (src_act[s] && src_lvl[s] > best_lvl) begin
        best_lvl = src_lvl[s];
        best_code = src_code[s];
        best_alt = src_alt[s];
      end
    end
    st_nxt.req.valid = best_lvl > cpu_mask_level;
    st_nxt.req.level = best_lvl;
    st_nxt.req.code = best_code;
    st_nxt.req.code_alt = best_alt;

    for (int s = 1; s < 10; s++) begin
      if (src_act[s] && src_lvl[s] > cpu_mask_level) begin
        pins_wake = 1'b1;
      end
    end
    st_nxt.wake = standby && rtc_running && pins_wake;

    if (cpu_accept && st_r.req.valid) begin
      st_nxt.event_code = st_r.req.code;
      st_nxt.event_code_alt = st_r.req.code_alt;
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_q2_r) begin
    if (!rst_q2_r) begin
      st_r <= '0;
      st_r.ext_s1 <= '1;
      st_r.ext_s2 <= '1;
      st_r.ext_prev <= '1;
      st_r.bus_s1 <= irq_intake_pkg::BUS_IDLE;
      st_r.bus_s2 <= irq_intake_pkg::BUS_IDLE;
      st_r.bus_prev <= irq_intake_pkg::BUS_IDLE;
      st_r.bus_stable <= irq_intake_pkg::BUS_IDLE;
      st_r.sense <= irq_intake_pkg::SENSE_RESET;
      st_r.prio_c <= irq_intake_pkg::PRIO_RESET;
      st_r.prio_d <= irq_intake_pkg::PRIO_RESET;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  assign req = st_r.req;
  assign wake = st_r.wake;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_flag_clear_armed;
    @(posedge clock) disable iff (!rst_q2_r)
      ((($past(st_r.flags) & ~st_r.flags & $past(st_r.sense) & st_r.sense) & ~$past(st_r.armed)) == 6'h00);
  endproperty
  a_flag_clear_armed: assert property (p_flag_clear_armed) else $error("edge flag cleared without read of 1");

  property p_level_follows_pin;
    @(posedge clock) disable iff (!rst_q2_r)
      (ce && sample_en && !st_r.sense[0] && !$past(st_r.sense[0])) |=> (st_r.flags[0] == !$past(st_r.ext_s2[0]));
  endproperty
  a_level_follows_pin: assert property (p_level_follows_pin) else $error("level flag does not follow pin");

  property p_bus_decode;
    @(posedge clock) disable iff (!rst_q2_r)
      (ce && st_nxt.req.valid && st_nxt.req.code == irq_intake_pkg::CODE_BUS)
        |=> (st_r.req.level == (4'hf ^ $past(st_r.bus_stable)));
  endproperty
  a_bus_decode: assert property (p_bus_decode) else $error("bus level decode wrong");

  sequence s_two_equal;
    $past(st_r.bus_s2) == st_r.bus_stable && $past(st_r.bus_prev) == st_r.bus_stable;
  endsequence
  property p_bus_filter;
    @(posedge clock) disable iff (!rst_q2_r)
      $changed(st_r.bus_stable) |-> s_two_equal;
  endproperty
  a_bus_filter: assert property (p_bus_filter) else $error("bus value taken without two equal samples");

  property p_group_prio;
    @(posedge clock) disable iff (!rst_q2_r)
      (ce && st_r.req.valid && st_r.req.code == irq_intake_pkg::CODE_PINT_LO && $stable(st_r.prio_d))
        |-> st_r.req.level == st_r.prio_d[15:12];
  endproperty
  a_group_prio: assert property (p_group_prio) else $error("port group priority not applied");

  property p_debug_fixed;
    @(posedge clock) disable iff (!rst_q2_r)
      (st_r.req.valid && st_r.req.code == irq_intake_pkg::CODE_DEBUG) |-> st_r.req.level == 4'hf;
  endproperty
  a_debug_fixed: assert property (p_debug_fixed) else $error("debug source level not 15");

  property p_zero_masked;
    @(posedge clock) disable iff (!rst_q2_r)
      (st_r.req.valid && $past(ce)) |-> (st_r.req.level != 4'h0 && st_r.req.level > $past(cpu_mask_level));
  endproperty
  a_zero_masked: assert property (p_zero_masked) else $error("masked or level 0 request offered");

  property p_wake_rtc;
    @(posedge clock) disable iff (!rst_q2_r)
      $rose(st_r.wake) |-> ($past(standby) && $past(rtc_running));
  endproperty
  a_wake_rtc: assert property (p_wake_rtc) else $error("wake without standby and running RTC");

endmodule

// [bench/irq_cpu_model.sv]
/*
  CPU-side partner: takes an offered request after a set delay.
  Assumes the intake's registered req output and a single clock.
*/
`timescale 1ns/1ns
module irq_cpu_model (
  input wire logic clock,
  input wire logic en,
  input wire logic [3:0] lat,
  input wire irq_intake_pkg::irq_req_t req,
  output logic cpu_accept
);
  int wait_cnt = 0;

  initial cpu_accept = 1'b0;

  always @(posedge clock) begin
    cpu_accept <= 1'b0;
    if (!en || !req.valid || cpu_accept) begin
      wait_cnt <= 0;
    end else if (wait_cnt >= int'(lat)) begin
      cpu_accept <= 1'b1;
      wait_cnt <= 0;
    end else begin
      wait_cnt <= wait_cnt + 1;
    end
  end
endmodule

// [bench/irq_source_intake_bench.sv]
/*
  Self-checking bench for the request intake, with a behavioural model.
  Assumes the CPU partner model and the intake package are compiled first.
*/
`timescale 1ns/1ns
module irq_source_intake_bench;
  logic clock = 1'b0;
  logic rst_n = 1'b1;
  logic ce = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [15:0] rdata;
  logic [5:0] pins_n = 6'h3f;
  logic [3:0] bus = 4'hf;
  logic [15:0] port = 16'h0000;
  logic [9:0] mod_irq = 10'h000;
  logic [3:0] mask = 4'h0;
  logic cpu_accept;
  logic standby = 1'b0;
  logic rtc_on = 1'b0;
  logic rtc_tick = 1'b0;
  logic cpu_en = 1'b0;
  logic [1:0] tcnt = 2'h0;
  irq_intake_pkg::irq_req_t req;
  logic wake;
  logic [15:0] shadow [16];
  logic [5:0] sense = 6'h00;
  logic [5:0] eflag = 6'h00;
  logic [15:0] rd_val;
  logic [15:0] tmp;
  int err_count = 0;
  int n_compared = 0;
  int k;

  irq_source_intake uut (.clock(clock), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .ext_request_pins_n(pins_n),
    .encoded_prio_bus(bus), .port_request_pins(port), .module_irq(mod_irq),
    .cpu_mask_level(mask), .cpu_accept(cpu_accept), .standby(standby),
    .rtc_running(rtc_on), .rtc_tick(rtc_tick), .req(req), .wake(wake));
  irq_cpu_model partner (.clock(clock), .en(cpu_en), .lat(4'h2), .req(req), .cpu_accept(cpu_accept));

  initial forever #20 clock = ~clock;

  // Slow tick standing in for the real-time clock
  always @(posedge clock) begin
    tcnt <= tcnt + 2'h1;
    rtc_tick <= (tcnt == 2'h3);
  end

  // ------------------------------------------------------------
  // Bus tasks and comparison
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
    if (ce && a <= 4'h9) shadow[a] = d;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask

  // ------------------------------------------------------------
  // Model: sources in default order, earlier wins ties
  // ------------------------------------------------------------
  function automatic void src(input int s, output bit on, output int lv, output logic [11:0] c);
    int m;
    m = s - 10;
    on = (s == 0) ? mod_irq[9] : (s == 1) ? (bus != 4'hf) : (s < 8) ?
      (sense[s-2] ? eflag[s-2] : !pins_n[s-2]) : (s == 8) ? |port[7:0] : (s == 9) ? |port[15:8] : mod_irq[m];
    lv = (s == 0) ? 15 : (s == 1) ? 15 - int'(bus) : (s < 6) ? int'(shadow[0][4*(s-2)+:4]) :
      (s < 8) ? int'(shadow[1][4*(s-6)+:4]) : (s == 8) ? int'(shadow[1][15:12]) :
      (s == 9) ? int'(shadow[1][11:8]) : int'(shadow[2+m/4][15-4*(m%4)-:4]);
    c = (s == 0) ? irq_intake_pkg::CODE_DEBUG : (s == 1) ? irq_intake_pkg::CODE_BUS :
      (s < 8) ? irq_intake_pkg::CODE_IRQ_BASE + 12'(32 * (s - 2)) : (s == 8) ? irq_intake_pkg::CODE_PINT_LO :
      (s == 9) ? irq_intake_pkg::CODE_PINT_HI : irq_intake_pkg::CODE_MOD_BASE + 12'(64 * m);
  endfunction

  task automatic look();
    bit on;
    int lv;
    int best;
    logic [11:0] c;
    logic [11:0] bc;
    repeat (8) @(posedge clock);
    #1 best = 0;
    bc = 12'h000;
    for (int s = 0; s < 19; s++) begin
      src(s, on, lv, c);
      if (on && lv > best) begin
        best = lv;
        bc = c;
      end
    end
    chk("req_valid", 16'(req.valid), 16'(best > int'(mask)));
    if (best > int'(mask)) begin
      chk("req_level", 16'(req.level), 16'(best));
      chk("req_code", 16'(req.code), 16'(bc));
      chk("req_alt", 16'(req.code_alt), 16'(bc + ((bc == irq_intake_pkg::CODE_BUS) ? 12'(32 * int'(bus)) : 12'h000)));
    end
  endtask

  task automatic wait_wake(input logic exp);
    // Minimum dwell, so a pin that must not wake is seen over several ticks
    repeat (16) @(posedge clock);
    for (int i = 0; i < 60 && wake !== exp; i++) @(posedge clock);
    #1 chk("wake", 16'(wake), 16'(exp));
  endtask

  task automatic complete_run();
    if (err_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    complete_run();
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    // Real falling edge at time 0 so the reset copy is never unknown
    rst_n <= 1'b0;
    k = $urandom(97);
    for (k = 0; k < 16; k++) shadow[k] = 16'h0000;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    for (k = 0; k < 16; k++) begin
      rd(4'(k), rd_val);
      if (k < 12 || k > 13) chk("reset_reg", rd_val, (k == 14) ? 16'h000f : 16'h0000);
    end
    for (k = 0; k < 6; k++) begin
      tmp = shadow[k/4];
      tmp[4*(k%4)+:4] = (k == 0) ? 4'h0 : 4'($urandom_range(15, 1));
      wr(4'(k / 4), tmp);
      mask <= 4'($urandom_range(15, 0));
      pins_n[k] <= 1'b0;
      look();
      pins_n[k] <= 1'b1;
      look();
    end
    mask <= 4'h0;
    wr(4'h0, 16'h0077);
    pins_n <= 6'h3c;
    look();
    pins_n <= 6'h3f;
    bus <= 4'h0;
    mod_irq[9] <= 1'b1;
    look();
    mod_irq <= 10'h000;
    for (k = 0; k < 16; k++) begin
      bus <= 4'(k);
      look();
    end
    bus <= 4'h2;
    @(posedge clock);
    bus <= 4'hf;
    look();
    rd(irq_intake_pkg::IDX_STATUS, rd_val);
    chk("status", rd_val, 16'h000f);
    wr(4'h1, 16'h5a00);
    for (k = 0; k < 3; k++) begin
      port <= (k == 0) ? 16'h0100 : (k == 1) ? 16'h0081 : 16'h8001;
      look();
    end
    port <= 16'h0000;
    for (k = 2; k < 10; k++) wr(4'(k), 16'($urandom));
    for (k = 0; k < 10; k++) begin
      mod_irq <= 10'(1 << k);
      look();
    end
    mod_irq <= 10'h000;
    // sense changed under mask, stale flags cleared
    mask <= 4'hf;
    wr(4'h0, 16'h0900);
    wr(irq_intake_pkg::IDX_SENSE, 16'h0004);
    sense = 6'h04;
    rd(irq_intake_pkg::IDX_EXT_FLAGS, rd_val);
    wr(irq_intake_pkg::IDX_EXT_FLAGS, 16'h0000);
    mask <= 4'h0;
    pins_n[2] <= 1'b0;
    repeat (3) @(posedge clock);
    pins_n[2] <= 1'b1;
    eflag = 6'h04;
    look();
    wr(irq_intake_pkg::IDX_EXT_FLAGS, 16'h0000);
    look();
    rd(irq_intake_pkg::IDX_EXT_FLAGS, rd_val);
    chk("flags_set", rd_val, 16'h0004);
    wr(irq_intake_pkg::IDX_EXT_FLAGS, 16'h0000);
    eflag = 6'h00;
    look();
    wr(irq_intake_pkg::IDX_SENSE, 16'h0000);
    sense = 6'h00;
    bus <= 4'h3;
    cpu_en <= 1'b1;
    for (k = 0; k < 30 && cpu_accept !== 1'b1; k++) #40;
    cpu_en <= 1'b0;
    chk("accept", 16'(cpu_accept), 16'h0001);
    repeat (2) @(posedge clock);
    bus <= 4'hf;
    rd(irq_intake_pkg::IDX_EVENT, rd_val);
    chk("event", rd_val, 16'h0200);
    rd(irq_intake_pkg::IDX_EVENT_ALT, rd_val);
    chk("event_alt", rd_val, 16'h0260);
    ce <= 1'b0;
    wr(4'h0, 16'h1234);
    ce <= 1'b1;
    rd(4'h0, rd_val);
    chk("ce_hold", rd_val, shadow[0]);
    wr(4'h0, 16'h0005);
    wr(4'h1, 16'h5000);
    standby <= 1'b1;
    rtc_on <= 1'b1;
    mask <= 4'h3;
    for (k = 0; k < 4; k++) begin
      if (k == 3) rtc_on <= 1'b0;
      pins_n[0] <= (k != 0 && k != 3);
      port[0] <= (k == 1);
      bus <= (k == 2) ? 4'h0 : 4'hf;
      wait_wake(k != 3);
      pins_n <= 6'h3f;
      port <= 16'h0000;
      bus <= 4'hf;
      rtc_on <= 1'b1;
      wait_wake(1'b0);
    end
    complete_run();
  end
endmodule
